// ---- design/qcc_control_memory.sv ----
// Control memory and command interpreter for a four-channel voice codec.
// Assumes a host master on select/clock/data pins, all asynchronous to core_clk_i.
`timescale 1ns/1ns
`default_nettype none
module qcc_control_memory
    import qcc_pkg::*;
#(
    parameter int unsigned MEM_DEPTH = 256,
    parameter int unsigned SW_RESET_QUIET_CYC = QCC_SW_RESET_QUIET_CYC
) (
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic sel_n_i,
    input wire logic control_serial_clock_i,
    input wire logic serial_command_input_i,
    output logic serial_data_out_o,
    output logic serial_data_out_oe_o,
    input wire logic [QCC_CHANNELS*QCC_LATCH_BITS-1:0] latch_pin_i,
    output logic [QCC_CHANNELS*QCC_LATCH_BITS-1:0] latch_pin_o,
    output logic [QCC_CHANNELS*QCC_LATCH_BITS-1:0] latch_pin_oe_o,
    output logic [QCC_CHANNELS-1:0] rx_input_enable_o,
    output logic [QCC_CHANNELS-1:0] tx_input_enable_o,
    output logic [QCC_CHANNELS-1:0] sw_reset_busy_o,
    output qcc_chan_ctrl_t chan_ctrl_o
);
    if (MEM_DEPTH != 256) begin : g_bad_depth
        $error("MEM_DEPTH must be 256");
    end
    if (SW_RESET_QUIET_CYC < 1) begin : g_bad_quiet
        $error("SW_RESET_QUIET_CYC must be positive");
    end

    typedef enum logic [2:0] {
        QCC_ST_CMD,
        QCC_ST_ADDR,
        QCC_ST_LEN,
        QCC_ST_DATA,
        QCC_ST_IGNORE
    } qcc_state_t;

    localparam int unsigned LB = QCC_LATCH_BITS;

    logic [7:0] mem_reg [QCC_CHANNELS][MEM_DEPTH];
    logic sel_s;
    logic sel_n_s;
    logic sclk_s;
    logic sdi_s;
    logic [QCC_CHANNELS*LB-1:0] latch_in_s;
    logic sclk_prev_reg;
    logic sel_prev_reg;
    logic sclk_rise;
    logic sclk_fall;
    logic sel_rise;
    logic byte_valid;
    logic [7:0] rx_byte;
    logic sdo;
    logic load_out;
    logic [7:0] load_byte;
    qcc_state_t state_reg;
    logic [3:0] op_reg;
    logic [1:0] chan_reg;
    logic [7:0] addr_reg;
    logic [7:0] len_reg;
    logic read_pending_reg;
    logic read_frame_reg;
    logic fast_scan_reg;
    logic [1:0] post_cnt_reg;
    logic init_reg;
    logic [7:0] init_addr_reg;
    logic [QCC_CHANNELS-1:0] rst_bit_reg;
    logic [31:0] quiet_cnt_reg [QCC_CHANNELS];
    logic [7:0] out_addr_reg;

    qcc_sync #(.WIDTH(3 + QCC_CHANNELS*LB)) u_sync (
        .core_clk_i(core_clk_i),
        .rst_i(rst_i),
        .async_i({~sel_n_i, control_serial_clock_i, serial_command_input_i, latch_pin_i}),
        .sync_o({sel_s, sclk_s, sdi_s, latch_in_s})
    );
    // Select travels inverted so a cleared synchroniser reads as deselected
    assign sel_n_s = !sel_s;

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            sclk_prev_reg <= 1'b0;
            sel_prev_reg <= 1'b1;
        end else begin
            sclk_prev_reg <= sclk_s;
            sel_prev_reg <= sel_n_s;
        end
    end

    assign sclk_rise = sclk_s && !sclk_prev_reg;
    assign sclk_fall = !sclk_s && sclk_prev_reg;
    assign sel_rise = sel_n_s && !sel_prev_reg;

    qcc_serial_port u_port (
        .core_clk_i(core_clk_i),
        .rst_i(rst_i),
        .sel_n_i(sel_n_s),
        .sclk_rise_i(sclk_rise),
        .sclk_fall_i(sclk_fall),
        .sdi_i(sdi_s),
        .load_i(load_out),
        .load_byte_i(load_byte),
        .byte_valid_o(byte_valid),
        .byte_o(rx_byte),
        .sdo_o(sdo)
    );

    function automatic logic [7:0] pin_state(input logic [1:0] ch, input logic [QCC_CHANNELS*LB-1:0] pins);
        logic [7:0] v;
        v = 8'h00;
        v[LB-1:0] = pins[ch*LB +: LB];
        return v;
    endfunction : pin_state

    function automatic logic [7:0] read_byte(input logic [1:0] ch, input logic [7:0] a,
                                             input logic [QCC_CHANNELS*LB-1:0] pins);
        logic [7:0] v;
        v = (a == QCC_ADDR_LATCH_STATE) ? pin_state(ch, pins) : mem_reg[ch][a];
        return v;
    endfunction : read_byte

    // Fast-scan reply: bits 0 and 1 of each channel, channel 0 lowest
    function automatic logic [7:0] scan_byte(input logic [QCC_CHANNELS*LB-1:0] pins);
        logic [7:0] v;
        v = 8'h00;
        for (int c = 0; c < QCC_CHANNELS; c++) begin
            v[c*2 +: 2] = pins[c*LB +: 2];
        end
        return v;
    endfunction : scan_byte

    // Response is prepared only after select rises and two clocks pass
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            post_cnt_reg <= 2'h0;
            read_frame_reg <= 1'b0;
            out_addr_reg <= 8'h00;
            load_out <= 1'b0;
            load_byte <= 8'h00;
        end else begin
            load_out <= 1'b0;
            if (sel_rise && read_pending_reg) begin
                post_cnt_reg <= 2'(QCC_POST_CLOCKS);
                out_addr_reg <= addr_reg;
            end else if (post_cnt_reg != 2'h0 && sclk_rise) begin
                post_cnt_reg <= post_cnt_reg - 2'h1;
                if (post_cnt_reg == 2'h1) begin
                    read_frame_reg <= 1'b1;
                    load_out <= 1'b1;
                    load_byte <= fast_scan_reg ? scan_byte(latch_in_s)
                                               : read_byte(chan_reg, addr_reg, latch_in_s);
                end
            end
            // Multibyte reads step upward, LSB byte first
            if (read_frame_reg && byte_valid) begin
                out_addr_reg <= out_addr_reg + 8'h01;
                load_out <= 1'b1;
                load_byte <= read_byte(chan_reg, out_addr_reg + 8'h01, latch_in_s);
            end
            if (read_frame_reg && sel_rise) begin
                read_frame_reg <= 1'b0;
            end
        end
    end

    // Command decode; second select excursion of a read carries no command
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            state_reg <= QCC_ST_CMD;
            op_reg <= 4'h0;
            chan_reg <= 2'h0;
            addr_reg <= 8'h00;
            len_reg <= 8'h00;
            read_pending_reg <= 1'b0;
            fast_scan_reg <= 1'b0;
        end else if (sel_n_s) begin
            state_reg <= read_frame_reg ? QCC_ST_IGNORE : QCC_ST_CMD;
            if (sel_rise && !read_pending_reg) begin
                fast_scan_reg <= 1'b0;
            end
            if (post_cnt_reg == 2'h1 && sclk_rise) begin
                read_pending_reg <= 1'b0;
            end
        end else if (byte_valid) begin
            unique case (state_reg)
                QCC_ST_CMD: begin
                    if (rx_byte == QCC_CMD_FAST_SCAN) begin
                        fast_scan_reg <= 1'b1;
                        read_pending_reg <= 1'b1;
                        state_reg <= QCC_ST_IGNORE;
                    end else begin
                        op_reg <= rx_byte[7:4];
                        chan_reg <= rx_byte[1:0];
                        state_reg <= QCC_ST_ADDR;
                    end
                end
                QCC_ST_ADDR: begin
                    addr_reg <= rx_byte;
                    state_reg <= QCC_ST_LEN;
                end
                QCC_ST_LEN: begin
                    len_reg <= rx_byte;
                    if (op_reg == QCC_OP_READ) begin
                        read_pending_reg <= 1'b1;
                        state_reg <= QCC_ST_IGNORE;
                    end else begin
                        state_reg <= QCC_ST_DATA;
                    end
                end
                QCC_ST_DATA: begin
                    addr_reg <= addr_reg + 8'h01;
                    len_reg <= len_reg - 8'h01;
                    if (len_reg == 8'h01) state_reg <= QCC_ST_IGNORE;
                end
                QCC_ST_IGNORE: begin
                    state_reg <= QCC_ST_IGNORE;
                end
            endcase
        end
    end

    // Memory writes, hardware default load, software reset effects
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            init_reg <= 1'b1;
            init_addr_reg <= 8'h00;
        end else if (init_reg) begin
            for (int c = 0; c < QCC_CHANNELS; c++) begin
                mem_reg[c][init_addr_reg] <= QCC_DEFAULT_BYTE;
                mem_reg[c][QCC_ADDR_LATCH_DIR] <= QCC_RESET_LATCH_DIR;
                mem_reg[c][QCC_ADDR_LATCH_OUT] <= QCC_RESET_LATCH_OUT;
                mem_reg[c][QCC_ADDR_ACTIVATION] <= QCC_RESET_ACTIVATION;
            end
            init_addr_reg <= init_addr_reg + 8'h01;
            if (init_addr_reg == 8'(MEM_DEPTH - 1)) init_reg <= 1'b0;
        end else begin
            if (!sel_n_s && byte_valid && state_reg == QCC_ST_DATA
                && addr_reg <= QCC_ADDR_LAST_WRITABLE && addr_reg != QCC_ADDR_LATCH_STATE) begin
                for (int c = 0; c < QCC_CHANNELS; c++) begin
                    if (op_reg == QCC_OP_WRITE_ALL || (op_reg == QCC_OP_WRITE && chan_reg == 2'(c))) begin
                        mem_reg[c][addr_reg] <= rx_byte;
                    end
                end
            end
            for (int c = 0; c < QCC_CHANNELS; c++) begin
                if (rst_bit_reg[c]) begin
                    mem_reg[c][QCC_ADDR_LATCH_DIR] <= QCC_RESET_LATCH_DIR;
                    mem_reg[c][QCC_ADDR_LATCH_OUT] <= QCC_RESET_LATCH_OUT;
                    mem_reg[c][QCC_ADDR_ACTIVATION] <= QCC_RESET_ACTIVATION;
                end
            end
        end
    end

    // Software reset acts on a set bit, per channel only
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            rst_bit_reg <= '0;
            sw_reset_busy_o <= '0;
            for (int c = 0; c < QCC_CHANNELS; c++) quiet_cnt_reg[c] <= 32'h0;
        end else begin
            for (int c = 0; c < QCC_CHANNELS; c++) begin
                rst_bit_reg[c] <= !init_reg && mem_reg[c][QCC_ADDR_RESET_CTRL] != 8'h00;
                if (rst_bit_reg[c]) begin
                    quiet_cnt_reg[c] <= 32'(SW_RESET_QUIET_CYC);
                end else if (quiet_cnt_reg[c] != 32'h0) begin
                    quiet_cnt_reg[c] <= quiet_cnt_reg[c] - 32'h1;
                end
                sw_reset_busy_o[c] <= rst_bit_reg[c] || quiet_cnt_reg[c] > 32'h1;
            end
        end
    end

    // Registered pin and control outputs
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            latch_pin_o <= '0;
            latch_pin_oe_o <= {QCC_CHANNELS{QCC_RESET_LATCH_DIR[LB-1:0]}};
            rx_input_enable_o <= '0;
            tx_input_enable_o <= '0;
            chan_ctrl_o <= '0;
            serial_data_out_o <= 1'b0;
            serial_data_out_oe_o <= 1'b0;
        // Reset values stand until the sweep has filled memory
        end else if (!init_reg) begin
            serial_data_out_o <= sdo;
            serial_data_out_oe_o <= read_frame_reg && !sel_n_s;
            for (int c = 0; c < QCC_CHANNELS; c++) begin
                latch_pin_o[c*LB +: LB] <= mem_reg[c][QCC_ADDR_LATCH_OUT][LB-1:0];
                latch_pin_oe_o[c*LB +: LB] <= mem_reg[c][QCC_ADDR_LATCH_DIR][LB-1:0];
                chan_ctrl_o.active[c] <= !init_reg && mem_reg[c][QCC_ADDR_ACTIVATION][QCC_ACTIVE_BIT];
                chan_ctrl_o.pcm_tx_en[c] <= mem_reg[c][QCC_ADDR_ACTIVATION][QCC_PCM_TX_EN_BIT];
                chan_ctrl_o.pcm_rx_en[c] <= mem_reg[c][QCC_ADDR_ACTIVATION][QCC_PCM_RX_EN_BIT];
                chan_ctrl_o.linear16[c] <= mem_reg[c][QCC_ADDR_ACTIVATION][QCC_LINEAR16_BIT];
                // Standby ignores transmit and receive signal inputs
                rx_input_enable_o[c] <= !init_reg && mem_reg[c][QCC_ADDR_ACTIVATION][QCC_ACTIVE_BIT];
                tx_input_enable_o[c] <= !init_reg && mem_reg[c][QCC_ADDR_ACTIVATION][QCC_ACTIVE_BIT];
                chan_ctrl_o.slot_loop[c] <= mem_reg[c][QCC_ADDR_TX_SLOT] == mem_reg[c][QCC_ADDR_RX_SLOT];
                chan_ctrl_o.loopback[c*3 +: 3] <= mem_reg[c][QCC_ADDR_LOOPBACK][2:0];
                unique case (mem_reg[c][QCC_ADDR_GAIN_SETTING][1:0])
                    2'h0: chan_ctrl_o.adapt_taps[c*7 +: 7] <= 7'd8;
                    2'h1: chan_ctrl_o.adapt_taps[c*7 +: 7] <= 7'd16;
                    2'h2: chan_ctrl_o.adapt_taps[c*7 +: 7] <= 7'd32;
                    2'h3: chan_ctrl_o.adapt_taps[c*7 +: 7] <= 7'd64;
                endcase
            end
        end
    end
    // Fixed coefficients 0..127 are written only by the host and the default load; no adaptation path writes them.
endmodule : qcc_control_memory
`default_nettype wire

// ---- design/qcc_pkg.sv ----
// Package for the quad codec control memory block.
// Assumes the serial control link is sampled on core_clk_i.
package qcc_pkg;
    localparam int unsigned QCC_CHANNELS = 4;
    localparam int unsigned QCC_LATCH_BITS = 6;
    localparam logic [7:0] QCC_CMD_FAST_SCAN = 8'h02;
    localparam logic [7:0] QCC_ADDR_RESET_CTRL = 8'h80;
    localparam logic [7:0] QCC_ADDR_ACTIVATION = 8'h81;
    localparam logic [7:0] QCC_ADDR_LATCH_DIR = 8'h9E;
    localparam logic [7:0] QCC_ADDR_LATCH_OUT = 8'h9F;
    localparam logic [7:0] QCC_ADDR_LATCH_STATE = 8'hA0;
    localparam logic [7:0] QCC_ADDR_LAST_WRITABLE = 8'hA2;
    localparam logic [7:0] QCC_ADDR_FIXED_COEFF_LAST = 8'h7F;
    localparam logic [7:0] QCC_ADDR_GAIN_SETTING = 8'h91;
    localparam logic [7:0] QCC_ADDR_LOOPBACK = 8'h92;
    localparam logic [7:0] QCC_ADDR_TX_SLOT = 8'h82;
    localparam logic [7:0] QCC_ADDR_RX_SLOT = 8'h83;
    // Command opcode: top bits select kind, low bits select channel
    localparam logic [3:0] QCC_OP_WRITE = 4'h4;
    localparam logic [3:0] QCC_OP_READ = 4'h8;
    localparam logic [3:0] QCC_OP_WRITE_ALL = 4'hC;
    localparam logic [7:0] QCC_RESET_LATCH_DIR = 8'h0C;
    localparam logic [7:0] QCC_RESET_LATCH_OUT = 8'h00;
    localparam logic [7:0] QCC_RESET_ACTIVATION = 8'h00;
    localparam logic [7:0] QCC_DEFAULT_BYTE = 8'h00;
    localparam int unsigned QCC_ACTIVE_BIT = 0;
    localparam int unsigned QCC_PCM_TX_EN_BIT = 1;
    localparam int unsigned QCC_PCM_RX_EN_BIT = 2;
    localparam int unsigned QCC_LINEAR16_BIT = 3;
    localparam int unsigned QCC_POST_CLOCKS = 2;
    localparam real QCC_SW_RESET_QUIET_US = 256.0;
    localparam real QCC_CLK_MHZ = 100.0;
    localparam int unsigned QCC_SW_RESET_QUIET_CYC = int'($floor(QCC_SW_RESET_QUIET_US * QCC_CLK_MHZ));

    typedef enum logic [2:0] {
        QCC_LB_NONE,
        QCC_LB_PCM_TO_PCM,
        QCC_LB_CONV_BOUNDARY,
        QCC_LB_DIGITAL_TX_RX,
        QCC_LB_PCM_LINE,
        QCC_LB_ANALOG
    } qcc_loopback_t;

    typedef struct packed {
        logic [QCC_CHANNELS-1:0] active;
        logic [QCC_CHANNELS-1:0] pcm_tx_en;
        logic [QCC_CHANNELS-1:0] pcm_rx_en;
        logic [QCC_CHANNELS-1:0] linear16;
        logic [QCC_CHANNELS-1:0] slot_loop;
        logic [QCC_CHANNELS*3-1:0] loopback;
        logic [QCC_CHANNELS*7-1:0] adapt_taps;
    } qcc_chan_ctrl_t;
endpackage : qcc_pkg

// ---- design/qcc_serial_port.sv ----
// Serial shifter for the control link: LSB-first bytes in and out.
// Assumes select and clock already synchronised; data sampled on rising clock.
`timescale 1ns/1ns
`default_nettype none
module qcc_serial_port (
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic sel_n_i,
    input wire logic sclk_rise_i,
    input wire logic sclk_fall_i,
    input wire logic sdi_i,
    input wire logic load_i,
    input wire logic [7:0] load_byte_i,
    output logic byte_valid_o,
    output logic [7:0] byte_o,
    output logic sdo_o
);
    logic [7:0] shift_in_reg;
    logic [2:0] bit_cnt_reg;
    logic [7:0] shift_out_reg;

    always_ff @(posedge core_clk_i) begin
        if (rst_i || sel_n_i) begin
            bit_cnt_reg <= 3'h0;
            byte_valid_o <= 1'b0;
            shift_in_reg <= 8'h00;
            byte_o <= 8'h00;
        end else begin
            byte_valid_o <= 1'b0;
            if (sclk_rise_i) begin
                shift_in_reg <= {sdi_i, shift_in_reg[7:1]};
                bit_cnt_reg <= bit_cnt_reg + 3'h1;
                if (bit_cnt_reg == 3'h7) begin
                    byte_valid_o <= 1'b1;
                    byte_o <= {sdi_i, shift_in_reg[7:1]};
                end
            end
        end
    end

    // Output shifts on falling edge so the master samples a settled bit
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            shift_out_reg <= 8'h00;
        end else if (load_i) begin
            shift_out_reg <= load_byte_i;
        // Eighth falling edge skipped so a reloaded byte keeps its first bit
        end else if (!sel_n_i && sclk_fall_i && bit_cnt_reg != 3'h0) begin
            shift_out_reg <= {1'b0, shift_out_reg[7:1]};
        end
    end

    assign sdo_o = shift_out_reg[0];
endmodule : qcc_serial_port
`default_nettype wire

// ---- design/qcc_sync.sv ----
// Two-stage synchroniser for pins from outside the core clock.
// Assumes a single clock, synchronous active-high reset.
`timescale 1ns/1ns
`default_nettype none
module qcc_sync #(
    parameter int unsigned WIDTH = 1
) (
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic [WIDTH-1:0] async_i,
    output logic [WIDTH-1:0] sync_o
);
    logic [WIDTH-1:0] stage_reg;

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            stage_reg <= '0;
            sync_o <= '0;
        end else begin
            stage_reg <= async_i;
            sync_o <= stage_reg;
        end
    end
endmodule : qcc_sync
`default_nettype wire

// ---- verification/qcc_control_memory_properties.sv ----
// Checker for the control memory block, bound to its top ports.
// Assumes synchronous active-high reset on the core clock.
`timescale 1ns/1ns
`default_nettype none
module qcc_cm_props
    import qcc_pkg::*;
#(
    parameter int unsigned SW_RESET_QUIET_CYC = 16
) (
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic sel_n_i,
    input wire logic control_serial_clock_i,
    input wire logic serial_data_out_oe_o,
    input wire logic [QCC_CHANNELS*QCC_LATCH_BITS-1:0] latch_pin_o,
    input wire logic [QCC_CHANNELS*QCC_LATCH_BITS-1:0] latch_pin_oe_o,
    input wire logic [QCC_CHANNELS-1:0] rx_input_enable_o,
    input wire logic [QCC_CHANNELS-1:0] tx_input_enable_o,
    input wire logic [QCC_CHANNELS-1:0] sw_reset_busy_o,
    input wire qcc_chan_ctrl_t chan_ctrl_o
);
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (rst_i);
    // Default load may take the whole memory sweep
    dflt_load_a: assert property ($fell(rst_i) |-> ##260 latch_pin_oe_o == {4{6'h0C}})
        else $error("latch direction defaults missing");
    sw_latch_a: assert property (sw_reset_busy_o[1] && $past(sw_reset_busy_o[1])
        |-> latch_pin_oe_o[11:6] == 6'h0C && latch_pin_o[9:8] == 2'h0)
        else $error("latch leads not reset");
    sw_standby_a: assert property (sw_reset_busy_o[1] ##1 sw_reset_busy_o[1] |-> !chan_ctrl_o.active[1])
        else $error("channel active during reset");
    standby_ignore_a: assert property (((rx_input_enable_o | tx_input_enable_o)
        & ~(chan_ctrl_o.active | $past(chan_ctrl_o.active))) == 4'h0)
        else $error("inputs enabled in standby");
    oe_idle_a: assert property (sel_n_i [*5] |-> !serial_data_out_oe_o)
        else $error("data out driven while deselected");
    oe_start_a: assert property ($rose(serial_data_out_oe_o) |-> !sel_n_i && $past(sel_n_i, 8))
        else $error("data out driven without response excursion");
    // Writes commit only on link activity, so a quiet link freezes the leads
    latch_hold_a: assert property ((sel_n_i && !control_serial_clock_i) [*8] |=> $stable(latch_pin_o))
        else $error("latch output changed without a write");
    busy_len_a: assert property ($rose(sw_reset_busy_o[1]) |=> sw_reset_busy_o[1] [*8])
        else $error("software reset window too short");
    cover property ($rose(serial_data_out_oe_o));
    cover property ($rose(sw_reset_busy_o[1]));
    cover property ($rose(chan_ctrl_o.active[2]));
endmodule : qcc_cm_props
bind qcc_control_memory qcc_cm_props #(.SW_RESET_QUIET_CYC(SW_RESET_QUIET_CYC)) u_props (
    .core_clk_i(core_clk_i), .rst_i(rst_i), .sel_n_i(sel_n_i),
    .control_serial_clock_i(control_serial_clock_i), .serial_data_out_oe_o(serial_data_out_oe_o),
    .latch_pin_o(latch_pin_o), .latch_pin_oe_o(latch_pin_oe_o), .rx_input_enable_o(rx_input_enable_o),
    .tx_input_enable_o(tx_input_enable_o), .sw_reset_busy_o(sw_reset_busy_o), .chan_ctrl_o(chan_ctrl_o));
`default_nettype wire

// ---- verification/qcc_host_model.sv ----
// Host master model for the serial control link.
// Assumes sdo_i is the resolved data-out wire from the bench.
`timescale 1ns/1ns
`default_nettype none
module qcc_host_model
    import qcc_pkg::*;
(
    input wire logic sdo_i,
    output logic sel_n_o,
    output logic sclk_o,
    output logic sdi_o
);
    initial begin
        sel_n_o = 1'b1;
        sclk_o = 1'b0;
        sdi_o = 1'b0;
    end
    // Gapped clock: n pulses between frames, otherwise stands still low
    task automatic pulses(input int n);
        repeat (n) begin
            #62 sclk_o = 1'b1;
            #63 sclk_o = 1'b0;
        end
    endtask : pulses
    task automatic byte_io(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 0; i < 8; i++) begin
            sdi_o = tx[i];
            #62 sclk_o = 1'b1;
            rx[i] = sdo_i;
            #63 sclk_o = 1'b0;
        end
        sdi_o = ~tx[7];
    endtask : byte_io
    task automatic frame(input logic [7:0] c, a, d, input int n, output logic [7:0] r);
        sel_n_o = 1'b0;
        #125 byte_io(c, r);
        if (n > 1) byte_io(a, r);
        if (n > 2) byte_io(8'h01, r);
        if (n > 3) byte_io(d, r);
        #62 sel_n_o = 1'b1;
    endtask : frame
    task automatic write(input logic [7:0] c, a, d);
        logic [7:0] r;
        frame(c, a, d, 4, r);
        pulses(4);
    endtask : write
    task automatic read(input logic [7:0] c, a, output logic [7:0] d);
        frame(c, a, 8'h00, (c == QCC_CMD_FAST_SCAN) ? 1 : 3, d);
        pulses(16);
        frame(8'hA5, 8'h00, 8'h00, 1, d);
        pulses(8);
    endtask : read
endmodule : qcc_host_model
`default_nettype wire

// ---- verification/quad_codec_control_memory_tb.sv ----
// Self-checking bench for the control memory block with a host model.
// Assumes the design package and a 100 MHz core clock.
`timescale 1ns/1ns
`default_nettype none
module quad_codec_control_memory_tb
    import qcc_pkg::*;
;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic sel_n, sclk, sdi, sdo, sdo_oe, sdo_w;
    logic [23:0] pin_i, pin_o, pin_oe, p, ext = '0, dir = {4{6'h0C}}, out = '0;
    logic [3:0] rx_en, tx_en, busy;
    qcc_chan_ctrl_t ctrl;
    logic [31:0] seed = 32'h67054C36;
    logic [7:0] r;
    logic [7:0] regs [4] = '{QCC_ADDR_RESET_CTRL, QCC_ADDR_ACTIVATION, QCC_ADDR_LATCH_DIR, QCC_ADDR_LATCH_OUT};
    logic [7:0] rst_v [4] = '{8'h00, QCC_RESET_ACTIVATION, QCC_RESET_LATCH_DIR, QCC_RESET_LATCH_OUT};
    int failures = 0;
    int compares = 0;
    always #5 clk = ~clk;
    // Released data line toggles so a stale bit never passes
    assign sdo_w = sdo_oe ? sdo : clk;
    assign pin_i = (pin_oe & pin_o) | (~pin_oe & ext);
    qcc_control_memory #(.SW_RESET_QUIET_CYC(16)) DUT (
        .core_clk_i(clk), .rst_i(rst), .sel_n_i(sel_n), .control_serial_clock_i(sclk),
        .serial_command_input_i(sdi), .serial_data_out_o(sdo), .serial_data_out_oe_o(sdo_oe),
        .latch_pin_i(pin_i), .latch_pin_o(pin_o), .latch_pin_oe_o(pin_oe), .rx_input_enable_o(rx_en),
        .tx_input_enable_o(tx_en), .sw_reset_busy_o(busy), .chan_ctrl_o(ctrl));
    qcc_host_model u_host (.sdo_i(sdo_w), .sel_n_o(sel_n), .sclk_o(sclk), .sdi_o(sdi));
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    function automatic logic [7:0] scan_exp(input logic [23:0] v);
        return {v[19:18], v[13:12], v[7:6], v[1:0]};
    endfunction : scan_exp
    task automatic chk24(input logic [23:0] got, exp, input string what);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk24
    task automatic chk8(input logic [7:0] got, exp, input string what);
        chk24({16'h0, got}, {16'h0, exp}, what);
    endtask : chk8
    task automatic wr(input logic [3:0] op, input logic [1:0] ch, input logic [7:0] a, d);
        u_host.write({op, 2'b00, ch}, a, d);
        @(negedge clk);
    endtask : wr
    task automatic rd(input logic [1:0] ch, input logic [7:0] a, output logic [7:0] d);
        u_host.read({QCC_OP_READ, 2'b00, ch}, a, d);
        @(negedge clk);
    endtask : rd
    task automatic print_verdict;
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : print_verdict
    initial begin
        #600000;
        failures++;
        $display("BAD %0t run hung", $time);
        print_verdict;
    end
    initial begin
        fork
            u_host.pulses(2);
        join_none
        repeat (5) @(negedge clk);
        rst = 1'b0;
        repeat (300) @(negedge clk);
        chk24(pin_oe, dir, "dir default");
        chk24({pin_o[23:4], ctrl.active}, '0, "out default");
        foreach (regs[i]) begin
            rd(2'd3, regs[i], r);
            chk8(r, rst_v[i], "reset value");
        end
        for (int k = 0; k < 4; k++) begin
            seed = lfsr(seed);
            dir = {4{seed[5:0]}};
            wr(QCC_OP_WRITE_ALL, 2'd0, QCC_ADDR_LATCH_DIR, {2'b00, seed[5:0]});
            chk24(pin_oe, dir, "dir all");
            seed = lfsr(seed);
            out[6*k +: 6] = seed[5:0];
            wr(QCC_OP_WRITE, k[1:0], QCC_ADDR_LATCH_OUT, {2'b00, seed[5:0]});
            chk24(pin_o, out, "out one");
            seed = lfsr(seed);
            ext = seed[23:0];
            p = (dir & out) | (~dir & ext);
            rd(k[1:0], QCC_ADDR_LATCH_STATE, r);
            chk8({2'b00, r[5:0]}, {2'b00, p[6*k +: 6]}, "lead state");
            u_host.read(QCC_CMD_FAST_SCAN, 8'h00, r);
            chk8(r, scan_exp(p), "fast scan");
        end
        wr(QCC_OP_WRITE, 2'd2, QCC_ADDR_ACTIVATION, 8'h0F);
        chk24({ctrl.active, ctrl.pcm_tx_en, ctrl.pcm_rx_en, ctrl.linear16, rx_en, tx_en}, {6{4'h4}}, "on");
        wr(QCC_OP_WRITE, 2'd2, QCC_ADDR_ACTIVATION, 8'h00);
        chk24({ctrl.active, ctrl.pcm_tx_en, ctrl.pcm_rx_en, ctrl.linear16, rx_en, tx_en}, '0, "off");
        for (int m = 0; m < 6; m++) begin
            wr(QCC_OP_WRITE, 2'd3, QCC_ADDR_LOOPBACK, 8'(m));
            chk24({21'h0, ctrl.loopback[9 +: 3]}, 24'(m), "loopback");
        end
        for (int g = 0; g < 4; g++) begin
            wr(QCC_OP_WRITE, 2'd0, QCC_ADDR_GAIN_SETTING, 8'(g));
            chk24({17'h0, ctrl.adapt_taps[6:0]}, 24'(8 << g), "taps");
        end
        seed = lfsr(seed);
        wr(QCC_OP_WRITE, 2'd1, QCC_ADDR_TX_SLOT, seed[7:0]);
        wr(QCC_OP_WRITE, 2'd1, QCC_ADDR_RX_SLOT, seed[7:0]);
        chk24({20'h0, ctrl.slot_loop}, 24'hF, "slot equal");
        wr(QCC_OP_WRITE, 2'd1, QCC_ADDR_RX_SLOT, ~seed[7:0]);
        chk24({20'h0, ctrl.slot_loop}, 24'hD, "slot differ");
        wr(QCC_OP_WRITE_ALL, 2'd0, {1'b0, seed[14:8]}, seed[23:16]);
        rd(2'd3, {1'b0, seed[14:8]}, r);
        chk8(r, seed[23:16], "coefficient");
        wr(QCC_OP_WRITE, 2'd0, QCC_ADDR_ACTIVATION, 8'h01);
        wr(QCC_OP_WRITE, 2'd1, QCC_ADDR_ACTIVATION, 8'h01);
        wr(QCC_OP_WRITE, 2'd1, QCC_ADDR_LATCH_DIR, 8'h3F);
        wr(QCC_OP_WRITE, 2'd1, QCC_ADDR_RESET_CTRL, 8'h01);
        chk24({busy, ctrl.active, 2'b00, pin_oe[11:6], 6'h00, pin_o[9:8]}, 24'h210C00, "sw reset");
        wr(QCC_OP_WRITE, 2'd1, QCC_ADDR_RESET_CTRL, 8'h00);
        for (int n = 0; n < 400 && busy !== 4'h0; n++) @(negedge clk);
        chk24({20'h0, busy}, '0, "quiet end");
        rd(2'd1, QCC_ADDR_ACTIVATION, r);
        chk8(r, 8'h00, "reset standby");
        rd(2'd0, QCC_ADDR_ACTIVATION, r);
        chk8(r, 8'h01, "other channel");
        print_verdict;
    end
endmodule : quad_codec_control_memory_tb
`default_nettype wire
